//--- design/tsdd_dec_if.sv
`timescale 1ns/1ps
interface tsdd_dec_if;
	logic [31:0] addr;
	logic [3:0] cmd;
	logic [3:0] cbe_n;
	logic addr_phase;
	logic frame_n;
	logic idsel;
	logic sub_mode;
	logic [31:0] range_base;
	logic [31:0] range_limit;
	logic range_io;
	logic [3:0] share_map;
	logic byte_check;
	logic hit;
	logic last_dw;
	logic be_bad;
	logic [3:0] be_keep;
	modport ctrl (output addr, cmd, cbe_n, addr_phase, frame_n, idsel, sub_mode, range_base,
		range_limit, range_io, share_map, byte_check, input hit, last_dw, be_bad, be_keep);
	modport dec (input addr, cmd, cbe_n, addr_phase, frame_n, idsel, sub_mode, range_base,
		range_limit, range_io, share_map, byte_check, output hit, last_dw, be_bad, be_keep);
endinterface

//--- design/tsdd_decode.sv
`timescale 1ns/1ps
module tsdd_decode
	import tsdd_pkg::*;
(
	tsdd_dec_if.dec bus
);
	function automatic logic [3:0] bytes_in(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [3:0] m;
		logic [31:0] b;
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			b = {a[31:2], 2'b00} + 32'(i);
			m[i] = (b >= lo) && (b <= hi);
		end
		return m;
	endfunction

	logic is_cfg;
	logic is_io;
	logic is_mem;
	logic [31:0] first_byte;
	logic [3:0] own;
	logic [3:0] en;
	logic fwd_mode;

	always_comb begin
		is_cfg = bus.cmd[3:1] == CMD_CFG_RD[3:1];
		is_io = bus.cmd[3:1] == CMD_IO_RD[3:1];
		is_mem = bus.cmd[3:1] == CMD_MEM_RD[3:1] || bus.cmd == CMD_MEM_RDM ||
			bus.cmd == CMD_MEM_RDL || bus.cmd == CMD_MEM_WRI;
		// Memory bursts use the low bits for ordering, so the first byte is dword aligned
		first_byte = bus.range_io ? bus.addr : {bus.addr[31:2], 2'b00};
		fwd_mode = bus.sub_mode && !bus.byte_check;
		en = ~bus.cbe_n;
		own = bytes_in(bus.addr, bus.range_base, bus.range_limit);
		if (bus.sub_mode && bus.byte_check)
			own = own & ~bus.share_map;
	end

	always_comb begin
		bus.hit = 1'b0;
		if (bus.addr_phase && !bus.frame_n) begin
			if (is_cfg)
				bus.hit = bus.idsel && bus.addr[1:0] == CFG_TYPE0;
			else if (bus.range_io ? is_io : is_mem)
				bus.hit = first_byte >= bus.range_base && first_byte <= bus.range_limit;
		end
	end

	// Configuration access is single dword, so every phase counts as the last
	assign bus.last_dw = is_cfg || bus.addr[31:2] >= bus.range_limit[31:2];
	// Forward mode lets stray bytes fall away rather than abort
	assign bus.be_bad = is_io && |(en & ~own) && !fwd_mode;
	assign bus.be_keep = fwd_mode ? (en & own) : en;
endmodule

//--- design/tsdd_pkg.sv
// Operation
// - Claim by asserting device-select one, two or three clocks after address phase; a DECODE_SPEED of 3 here claims after four.
// - Report the claim speed in a readable status field.
// - Device-select is asserted no later than target-ready, stop or read data.
// - Device-select holds until the last data phase, except during target-abort.
// - Subtractive claim only after no other agent claimed within three clocks.
// - Complete address and command decode before driving any target response.
// - Never drive device-select from a partial, combinationally settling decode.
// - Qualify address decode with frame for non-configuration commands.
// - Qualify init-select with frame and address bits 1 and 0 for configuration.
// - Subtractive claim may move one or two clocks earlier, not before slowest decoder.
// - Claim when first byte is in range; disconnect when burst crosses boundary.
// - Target-abort an I/O access whose byte enables reach outside the range.
// - Subtractive bridge may byte-map shared doublewords and target-abort on conflict.
// - Or forward the access and silently drop the bytes it cannot service.
// - Low-bandwidth devices buffer at least four doublewords.
// - High-bandwidth devices buffer at least 32 doublewords.
// - Prefer whole-line transfers; avoid transfers shorter than four doublewords.
// - A sink that can stall waits for buffer space instead of overrun buffering.
// - A time-critical stream loses data when its buffer is not drained.
package tsdd_pkg;
	// ==========================================
	// Bus commands
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_MEM_RDM = 4'hC;
	localparam logic [3:0] CMD_MEM_RDL = 4'hE;
	localparam logic [3:0] CMD_MEM_WRI = 4'hF;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;
	// ==========================================
	// Claim timing, counted in clocks after the address phase
	localparam logic [1:0] SPEED_FAST = 2'h0;
	localparam logic [2:0] SLOT_FAST = 3'h1;
	localparam logic [2:0] SUB_SLOT_BASE = 3'h4;
	localparam logic [2:0] SLOT_MAX = 3'h7;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	// ==========================================
	// Buffering
	localparam int BW_THRESH_MBPS = 5;
	localparam int MIN_BUF_LOW_DW = 4;
	localparam int MIN_BUF_HIGH_DW = 32;
	localparam int MIN_BURST_DW = 4;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CLAIM = 6'h02,
		ST_DATA = 6'h04,
		ST_ABORT = 6'h08,
		ST_TURN = 6'h10,
		ST_BUSY = 6'h20
	} tsdd_state_t;
endpackage

//--- design/tsdd_target.sv
`timescale 1ns/1ps
module tsdd_target
	import tsdd_pkg::*;
#(
	parameter int BUF_DW = MIN_BUF_LOW_DW,
	parameter bit HIGH_BW = 1'b0
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic FRAME_N,
	input wire logic IRDY_N,
	input wire logic IDSEL,
	input wire logic [3:0] CBE_N,
	input wire logic [31:0] AD_IN,
	output logic [31:0] AD_OUT,
	output logic AD_OE,
	input wire logic DEVSEL_N_IN,
	output logic DEVSEL_N_OUT,
	output logic DEVSEL_OE,
	output logic TRDY_N_OUT,
	output logic TRDY_OE,
	output logic STOP_N_OUT,
	output logic STOP_OE,
	input wire logic [1:0] DECODE_SPEED,
	input wire logic SUB_DECODE,
	input wire logic [1:0] SUB_PULLIN,
	input wire logic [1:0] SLOWEST_SPEED,
	input wire logic [31:0] RANGE_BASE,
	input wire logic [31:0] RANGE_LIMIT,
	input wire logic RANGE_IO,
	input wire logic [3:0] SHARE_MAP,
	input wire logic BYTE_CHECK,
	input wire logic STREAM_MODE,
	input wire logic LOST_CLR,
	output logic WR_VALID,
	input wire logic WR_READY,
	output logic [31:0] WR_DATA,
	output logic [3:0] WR_BE,
	input wire logic [31:0] RD_DATA,
	input wire logic RD_VALID,
	output logic RD_TAKE,
	output logic [1:0] DEVSEL_TIMING,
	output logic DATA_LOST,
	output logic TGT_ABORT
);
	// ==========================================
	// Buffer sizing
	localparam int MIN_DW = HIGH_BW ? MIN_BUF_HIGH_DW : MIN_BUF_LOW_DW;
	localparam int DEPTH = BUF_DW > MIN_DW ? BUF_DW : MIN_DW;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	function automatic logic [2:0] sub_slot(input logic [1:0] pull, input logic [1:0] slow);
		logic [2:0] s;
		logic [2:0] floor_s;
		s = SUB_SLOT_BASE - {1'b0, pull};
		floor_s = {1'b0, slow} + SLOT_FAST + SLOT_FAST;
		return (s < floor_s) ? floor_s : s;
	endfunction

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// ==========================================
	// State
	tsdd_state_t state_ff;
	logic [2:0] cnt_ff;
	logic [2:0] slot_ff;
	logic sub_ff;
	logic [3:0] cmd_ff;
	logic [31:0] addr_ff;
	logic bus_idle_ff;
	logic first_ff;
	logic devsel_n_ff;
	logic trdy_n_ff;
	logic stop_n_ff;
	logic oe_ff;
	logic ad_oe_ff;
	logic [31:0] ad_out_ff;
	logic rd_take_ff;
	logic [1:0] timing_ff;
	logic lost_ff;
	logic abort_ff;
	logic [31:0] wr_data_ff;
	logic [3:0] wr_be_ff;
	logic wr_valid_ff;
	logic [35:0] buf_mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;

	logic devsel_on;
	logic trdy_on;
	logic stop_on;
	logic addr_phase;
	logic is_wr;
	logic is_io;
	logic phase_done;
	logic last_done;
	logic claim_now;
	logic abort_now;
	logic full;
	logic push;
	logic push_ok;
	logic pop;
	logic drain_ok;
	logic [CW-1:0] nxt_count;
	logic [2:0] pos_slot;

	tsdd_dec_if dec_bus();
	tsdd_decode u_dec (
		.bus(dec_bus)
	);

	assign devsel_on = !devsel_n_ff;
	assign trdy_on = !trdy_n_ff;
	assign stop_on = !stop_n_ff;
	assign addr_phase = state_ff == ST_IDLE && bus_idle_ff && !FRAME_N;
	assign is_wr = cmd_ff[0];
	assign is_io = cmd_ff[3:1] == CMD_IO_RD[3:1];
	assign phase_done = (trdy_on || stop_on) && !IRDY_N;
	assign last_done = phase_done && FRAME_N;
	assign pos_slot = {1'b0, DECODE_SPEED} + SLOT_FAST;
	// Claim waits on the counter and, when subtractive, on every other agent staying silent
	assign claim_now = state_ff == ST_CLAIM && cnt_ff == slot_ff - SLOT_FAST &&
		!(sub_ff && !DEVSEL_N_IN);
	assign abort_now = state_ff == ST_DATA && first_ff && dec_bus.be_bad;

	// ==========================================
	// Decoder hookup
	always_comb begin
		dec_bus.addr = addr_ff;
		dec_bus.cmd = cmd_ff;
		if (addr_phase) begin
			dec_bus.addr = AD_IN;
			dec_bus.cmd = CBE_N;
		end else if (phase_done) begin
			dec_bus.addr = addr_ff + ADDR_STEP;
		end
	end
	assign dec_bus.cbe_n = CBE_N;
	assign dec_bus.addr_phase = addr_phase;
	assign dec_bus.frame_n = FRAME_N;
	assign dec_bus.idsel = IDSEL;
	assign dec_bus.sub_mode = sub_ff;
	assign dec_bus.range_base = RANGE_BASE;
	assign dec_bus.range_limit = RANGE_LIMIT;
	assign dec_bus.range_io = RANGE_IO;
	assign dec_bus.share_map = SHARE_MAP;
	assign dec_bus.byte_check = BYTE_CHECK;

	// ==========================================
	// Transaction sequencer
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 3'h0;
			slot_ff <= SLOT_FAST;
			sub_ff <= 1'b0;
			cmd_ff <= 4'h0;
			addr_ff <= 32'h0000_0000;
			first_ff <= 1'b0;
		end else begin
			if (cnt_ff != SLOT_MAX)
				cnt_ff <= cnt_ff + SLOT_FAST;
			if (phase_done)
				addr_ff <= addr_ff + ADDR_STEP;
			case (state_ff)
			ST_IDLE: begin
				if (addr_phase) begin
					cmd_ff <= CBE_N;
					addr_ff <= AD_IN;
					cnt_ff <= SLOT_FAST;
					first_ff <= 1'b1;
					if (dec_bus.hit) begin
						sub_ff <= 1'b0;
						slot_ff <= pos_slot;
						state_ff <= (pos_slot == SLOT_FAST) ? ST_DATA : ST_CLAIM;
					end else if (SUB_DECODE && CBE_N != CMD_SPECIAL &&
						CBE_N[3:1] != CMD_CFG_RD[3:1]) begin
						sub_ff <= 1'b1;
						slot_ff <= sub_slot(SUB_PULLIN, SLOWEST_SPEED);
						state_ff <= ST_CLAIM;
					end else begin
						state_ff <= ST_BUSY;
					end
				end
			end
			ST_CLAIM: begin
				if (FRAME_N && IRDY_N)
					state_ff <= ST_IDLE;
				else if (sub_ff && !DEVSEL_N_IN)
					state_ff <= ST_BUSY;
				else if (claim_now)
					state_ff <= ST_DATA;
			end
			ST_DATA: begin
				first_ff <= 1'b0;
				if (abort_now)
					state_ff <= ST_ABORT;
				else if (last_done)
					state_ff <= ST_TURN;
			end
			ST_ABORT: begin
				if (FRAME_N && !IRDY_N)
					state_ff <= ST_TURN;
			end
			ST_TURN: state_ff <= ST_IDLE;
			ST_BUSY: begin
				if (FRAME_N && IRDY_N)
					state_ff <= ST_IDLE;
			end
			default: state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST)
			bus_idle_ff <= 1'b0;
		else
			bus_idle_ff <= FRAME_N && IRDY_N;
	end

	// ==========================================
	// Claim and response signals, all registered from the finished decode
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			devsel_n_ff <= 1'b1;
			oe_ff <= 1'b0;
		end else begin
			if ((addr_phase && dec_bus.hit && pos_slot == SLOT_FAST) || claim_now) begin
				devsel_n_ff <= 1'b0;
				oe_ff <= 1'b1;
			end else if (abort_now || (state_ff == ST_DATA && last_done)) begin
				devsel_n_ff <= 1'b1;
			end else if (state_ff == ST_TURN) begin
				oe_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			trdy_n_ff <= 1'b1;
			stop_n_ff <= 1'b1;
			ad_oe_ff <= 1'b0;
			ad_out_ff <= 32'h0000_0000;
			rd_take_ff <= 1'b0;
		end else begin
			rd_take_ff <= 1'b0;
			if ((addr_phase && dec_bus.hit && pos_slot == SLOT_FAST && !CBE_N[0]) ||
				(claim_now && !is_wr))
				ad_oe_ff <= 1'b1;
			if (state_ff == ST_DATA) begin
				if (abort_now) begin
					trdy_n_ff <= 1'b1;
					stop_n_ff <= 1'b0;
					ad_oe_ff <= 1'b0;
				end else if (last_done) begin
					trdy_n_ff <= 1'b1;
					ad_oe_ff <= 1'b0;
				end else if (is_wr) begin
					// Stall rather than overrun unless the sink is a live stream
					if ((STREAM_MODE || nxt_count < CW'(DEPTH)) && !(stop_on && phase_done)) begin
						trdy_n_ff <= 1'b0;
						if (!FRAME_N && dec_bus.last_dw)
							stop_n_ff <= 1'b0;
					end else begin
						trdy_n_ff <= 1'b1;
					end
				end else if (phase_done) begin
					trdy_n_ff <= 1'b1;
				end else if (!trdy_on && !stop_on && RD_VALID) begin
					ad_out_ff <= RD_DATA;
					trdy_n_ff <= 1'b0;
					rd_take_ff <= 1'b1;
					if (!FRAME_N && dec_bus.last_dw)
						stop_n_ff <= 1'b0;
				end
			end else if (state_ff == ST_TURN) begin
				trdy_n_ff <= 1'b1;
				stop_n_ff <= 1'b1;
				ad_oe_ff <= 1'b0;
			end
		end
	end

	// ==========================================
	// Status
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			timing_ff <= SPEED_FAST;
			lost_ff <= 1'b0;
			abort_ff <= 1'b0;
		end else begin
			timing_ff <= DECODE_SPEED;
			abort_ff <= abort_now;
			// A new loss in the clearing cycle must not be missed
			if (push && full)
				lost_ff <= 1'b1;
			else if (LOST_CLR)
				lost_ff <= 1'b0;
		end
	end

	// ==========================================
	// Posted write buffer
	assign full = count_ff == CW'(DEPTH);
	assign push = state_ff == ST_DATA && is_wr && trdy_on && !IRDY_N;
	assign push_ok = push && !full;
	// Hold back the sink until a useful burst has gathered or the access is over
	assign drain_ok = count_ff >= CW'(MIN_BURST_DW) || state_ff != ST_DATA;
	assign pop = count_ff != '0 && drain_ok && (!wr_valid_ff || WR_READY);
	assign nxt_count = count_ff + CW'(push_ok) - CW'(pop);

	always_ff @(posedge SYS_CLK) begin
		if (push_ok)
			buf_mem[wr_ptr_ff] <= {dec_bus.be_keep, AD_IN};
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
			if (push_ok)
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			if (pop)
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			wr_valid_ff <= 1'b0;
			wr_data_ff <= 32'h0000_0000;
			wr_be_ff <= 4'h0;
		end else if (pop) begin
			wr_valid_ff <= 1'b1;
			{wr_be_ff, wr_data_ff} <= buf_mem[rd_ptr_ff];
		end else if (WR_READY) begin
			wr_valid_ff <= 1'b0;
		end
	end

	// ==========================================
	// Outputs
	assign AD_OUT = ad_out_ff;
	assign AD_OE = ad_oe_ff;
	assign DEVSEL_N_OUT = devsel_n_ff;
	assign DEVSEL_OE = oe_ff;
	assign TRDY_N_OUT = trdy_n_ff;
	assign TRDY_OE = oe_ff;
	assign STOP_N_OUT = stop_n_ff;
	assign STOP_OE = oe_ff;
	assign WR_VALID = wr_valid_ff;
	assign WR_DATA = wr_data_ff;
	assign WR_BE = wr_be_ff;
	assign RD_TAKE = rd_take_ff;
	assign DEVSEL_TIMING = timing_ff;
	assign DATA_LOST = lost_ff;
	assign TGT_ABORT = abort_ff;

	// ==========================================
	// Checks
	logic [2:0] since_addr_ff;
	logic last_cur;

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST)
			since_addr_ff <= 3'h0;
		else if (addr_phase)
			since_addr_ff <= SLOT_FAST;
		else if (since_addr_ff != SLOT_MAX)
			since_addr_ff <= since_addr_ff + SLOT_FAST;
	end
	assign last_cur = cmd_ff[3:1] == CMD_CFG_RD[3:1] || addr_ff[31:2] >= RANGE_LIMIT[31:2];

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	sequence s_abort_start;
		state_ff == ST_DATA && first_ff && is_io && dec_bus.be_bad;
	endsequence
	sequence s_final_phase;
		state_ff == ST_DATA && last_done && !abort_now;
	endsequence

	a_claim_slot_pos: assert property (
		$rose(devsel_on) && !sub_ff |-> since_addr_ff == {1'b0, timing_ff} + SLOT_FAST)
		else $error("positive claim at wrong clock");
	a_claim_slot_sub: assert property (
		$rose(devsel_on) && sub_ff |-> since_addr_ff <= SUB_SLOT_BASE &&
			since_addr_ff > {1'b0, SLOWEST_SPEED} + SLOT_FAST && $past(DEVSEL_N_IN))
		else $error("subtractive claim too early");
	a_resp_after_dev: assert property (
		(trdy_on || ad_oe_ff) |-> devsel_on)
		else $error("response driven without device-select");
	a_devsel_hold: assert property (
		devsel_on && !abort_now && !last_done |=> devsel_on)
		else $error("device-select dropped early");
	a_abort_form: assert property (
		s_abort_start |=> stop_on && !devsel_on && !trdy_on && state_ff == ST_ABORT)
		else $error("target-abort not signalled");
	a_turn_release: assert property (
		s_final_phase |=> state_ff == ST_TURN && oe_ff && !devsel_on ##1 !oe_ff)
		else $error("response pins not released after end");
	a_miss_quiet: assert property (
		state_ff == ST_BUSY |-> !oe_ff && !ad_oe_ff)
		else $error("driving while not claimed");
	a_disconnect: assert property (
		state_ff == ST_DATA && trdy_on && !FRAME_N && last_cur && phase_done |-> stop_on)
		else $error("no disconnect at range end");
	a_cfg_qualify: assert property (
		addr_phase && CBE_N[3:1] == CMD_CFG_RD[3:1] && !(IDSEL && AD_IN[1:0] == CFG_TYPE0)
		|=> state_ff == ST_BUSY)
		else $error("unqualified configuration claim");
	a_frame_qual: assert property (
		state_ff == ST_IDLE && FRAME_N |=> !oe_ff && !devsel_on)
		else $error("claim without frame");
	a_full_stall: assert property (
		state_ff == ST_DATA && is_wr && !STREAM_MODE && full |-> !trdy_on)
		else $error("write accepted into full buffer");
	a_stream_loss: assert property (
		push && full |=> lost_ff)
		else $error("lost stream data not flagged");
endmodule

//--- verif/target_device_select_decode_tb.sv
`timescale 1ns/1ps
module target_device_select_decode_tb
	import tsdd_pkg::*;
;
	typedef struct {
		logic [3:0] cmd;
		logic [31:0] addr;
		int n;
		logic [1:0] spd;
		logic sub;
		logic [1:0] pull, slow;
		logic ids, io;
		int clk, done, oth;
	} tsdd_row_t;
	// ==========================================
	// cmd addr n speed sub pullin slowest idsel io claim phases other
	tsdd_row_t rows[19] = '{
		'{CMD_MEM_WR, 32'h0000_1000, 1, 0, 0, 0, 0, 0, 0, 1, 1, 0},
		'{CMD_MEM_WR, 32'h0000_1004, 2, 1, 0, 0, 0, 0, 0, 2, 2, 0},
		'{CMD_MEM_WRI, 32'h0000_1010, 1, 2, 0, 0, 0, 0, 0, 3, 1, 0},
		'{CMD_MEM_RD, 32'h0000_1020, 1, 0, 0, 0, 0, 0, 0, 1, 1, 0},
		'{CMD_MEM_RDM, 32'h0000_1024, 1, 1, 0, 0, 0, 0, 0, 2, 1, 0},
		'{CMD_MEM_RDL, 32'h0000_1028, 1, 2, 0, 0, 0, 0, 0, 3, 1, 0},
		'{CMD_MEM_WR, 32'h0000_2000, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 0, 0, 0, 0, 4, 1, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 1, 0, 0, 0, 3, 1, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 2, 0, 0, 0, 2, 1, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 2, 2, 0, 0, 4, 1, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 2, 1, 0, 0, 3, 1, 0},
		'{CMD_MEM_RD, 32'h0000_2000, 1, 0, 1, 0, 0, 0, 0, 0, 0, 3},
		'{CMD_CFG_RD, 32'h0000_0000, 1, 0, 0, 0, 0, 1, 0, 1, 1, 0},
		'{CMD_CFG_RD, 32'h0000_0001, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0},
		'{CMD_CFG_RD, 32'h0000_0000, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0},
		'{CMD_SPECIAL, 32'h0000_0000, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0},
		'{CMD_IO_RD, 32'h0000_1000, 1, 0, 0, 0, 0, 0, 1, 1, 1, 0},
		'{CMD_MEM_WR, 32'h0000_10F8, 3, 0, 0, 0, 0, 0, 0, 1, 2, 0}
	};
	logic sys_clk = 1'b0, nrst = 1'b0, idsel = 1'b0, sub = 1'b0, rio = 1'b0, bchk = 1'b0;
	logic stream = 1'b0, lost_clr = 1'b0, wr_ready = 1'b1, rd_valid = 1'b1, ab_seen = 1'b0;
	logic [1:0] spd = 2'h0, pull = 2'h0, slow = 2'h0;
	logic [3:0] share = 4'h0;
	logic [31:0] limit = 32'h0000_10FF, rdat = 32'h1234_ABCD;
	logic frame_n, irdy_n, other_n, ad_oe, dsel_n, dsel_oe, trdy_n, trdy_oe, stop_n, stop_oe;
	logic wr_valid, rd_take, lost, tabort;
	logic [3:0] cbe_n, wr_be;
	logic [1:0] timing;
	logic [31:0] ad_m, ad_out, wr_data;
	logic [35:0] wr_q[$];
	int miscompares = 0, n_compared = 0, n_take = 0;
	wire [31:0] ad_w = ad_oe ? ad_out : ad_m;
	wire dsel_w = other_n & ~(dsel_oe & ~dsel_n);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	tsdd_master_model m (.clk(sys_clk), .frame_n(frame_n), .irdy_n(irdy_n), .cbe_n(cbe_n),
		.ad(ad_m), .other_n(other_n), .devsel_n(dsel_n), .devsel_oe(dsel_oe), .trdy_n(trdy_n),
		.trdy_oe(trdy_oe), .stop_n(stop_n), .stop_oe(stop_oe), .ad_out(ad_out), .ad_oe(ad_oe));
	tsdd_target #(.BUF_DW(4)) uut (
		.SYS_CLK(sys_clk), .NRST(nrst), .FRAME_N(frame_n), .IRDY_N(irdy_n), .IDSEL(idsel),
		.CBE_N(cbe_n), .AD_IN(ad_w), .AD_OUT(ad_out), .AD_OE(ad_oe), .DEVSEL_N_IN(dsel_w),
		.DEVSEL_N_OUT(dsel_n), .DEVSEL_OE(dsel_oe), .TRDY_N_OUT(trdy_n), .TRDY_OE(trdy_oe),
		.STOP_N_OUT(stop_n), .STOP_OE(stop_oe), .DECODE_SPEED(spd), .SUB_DECODE(sub),
		.SUB_PULLIN(pull), .SLOWEST_SPEED(slow), .RANGE_BASE(32'h0000_1000),
		.RANGE_LIMIT(limit), .RANGE_IO(rio), .SHARE_MAP(share), .BYTE_CHECK(bchk),
		.STREAM_MODE(stream), .LOST_CLR(lost_clr), .WR_VALID(wr_valid), .WR_READY(wr_ready),
		.WR_DATA(wr_data), .WR_BE(wr_be), .RD_DATA(rdat), .RD_VALID(rd_valid),
		.RD_TAKE(rd_take), .DEVSEL_TIMING(timing), .DATA_LOST(lost), .TGT_ABORT(tabort));
	always @(posedge sys_clk) begin
		if (wr_valid === 1'b1 && wr_ready)
			wr_q.push_back({wr_be, wr_data});
		if (tabort === 1'b1)
			ab_seen = 1'b1;
		if (rd_take === 1'b1)
			n_take++;
	end
	// ==========================================
	// Compare and sequence tasks
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_i(input int got, input int exp);
		chk(36'(got), 36'(exp));
	endtask
	task automatic chk_wr(input int n);
		chk_i(wr_q.size(), n);
		for (int i = 0; i < n && i < wr_q.size(); i++)
			chk(wr_q[i], {4'hF, 32'hD000_0000 + i});
	endtask
	task automatic chk_rst();
		chk({dsel_n, trdy_n, stop_n, dsel_oe, trdy_oe, stop_oe, ad_oe, wr_valid, rd_take,
			timing, lost, tabort}, 36'h0_0000_1C00);
		chk(ad_out, 36'h0_0000_0000);
	endtask
	task automatic run(input tsdd_row_t r);
		@(posedge sys_clk);
		#1;
		spd = r.spd;
		sub = r.sub;
		pull = r.pull;
		slow = r.slow;
		idsel = r.ids;
		rio = r.io;
		wr_q.delete();
		n_take = 0;
		m.xfer(r.cmd, r.addr, 4'h0, r.n, 0, r.oth);
		repeat (10) @(posedge sys_clk);
		chk_i(m.claim_clk, r.clk);
		chk_i(m.n_done, r.done);
		chk_i(m.order_bad, 0);
		chk(timing, r.spd);
		if (r.clk == 0)
			chk_i(m.drove, 0);
		if (r.cmd[0])
			chk_wr(r.done);
		else if (r.done > 0)
			chk(m.rd_q[0], rdat);
		if (!r.cmd[0])
			chk_i(n_take, r.done);
	endtask
	task automatic abort_case(input logic [31:0] a, input logic s, input logic b, input int c,
		input int d, input logic ab);
		@(posedge sys_clk);
		#1;
		{rio, limit, sub, bchk, share, pull, slow, ab_seen} = {1'b1, 32'h0000_100D, s, b,
			4'h8, 4'h0, 1'b0};
		m.xfer(CMD_IO_RD, a, 4'h0, 1, 0, 0);
		repeat (10) @(posedge sys_clk);
		chk_i(m.claim_clk, c);
		chk_i(m.n_done, d);
		chk(ab_seen, ab);
		chk_i(m.order_bad, 0);
		#1;
		{rio, limit, sub, bchk} = {1'b0, 32'h0000_10FF, 2'b00};
	endtask
	task automatic give_verdict();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		chk_rst();
		#1;
		nrst = 1'b1;
		repeat (2) @(posedge sys_clk);
		foreach (rows[i]) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		abort_case(32'h0000_100C, 1'b0, 1'b0, 1, 0, 1'b1);
		abort_case(32'h0000_3000, 1'b1, 1'b1, 4, 0, 1'b1);
		abort_case(32'h0000_3000, 1'b1, 1'b0, 4, 1, 1'b0);
		$display("abort tests done");
		// Stalled sink: target must hold off the bus, not lose data
		{wr_ready, spd} = {1'b0, 2'h0};
		wr_q.delete();
		fork
			m.xfer(CMD_MEM_WR, 32'h0000_1000, 4'h0, 6, 1, 0);
			begin
				repeat (30) @(posedge sys_clk);
				#1;
				wr_ready = 1'b1;
			end
		join
		repeat (10) @(posedge sys_clk);
		chk_i(m.n_done, 6);
		chk_wr(6);
		chk(lost, 1'b0);
		$display("stall test done");
		#1;
		{stream, wr_ready} = 2'b10;
		m.xfer(CMD_MEM_WR, 32'h0000_1000, 4'h0, 6, 0, 0);
		repeat (3) @(posedge sys_clk);
		chk_i(m.n_done, 6);
		chk(lost, 1'b1);
		#1;
		lost_clr = 1'b1;
		@(posedge sys_clk);
		#1;
		{lost_clr, stream, wr_ready} = 3'b001;
		@(posedge sys_clk);
		chk(lost, 1'b0);
		repeat (10) @(posedge sys_clk);
		$display("stream test done");
		#1;
		nrst = 1'b0;
		repeat (3) @(posedge sys_clk);
		chk_rst();
		#1;
		nrst = 1'b1;
		repeat (2) @(posedge sys_clk);
		run(rows[0]);
		$display("reset test done");
		give_verdict();
	end
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule

//--- verif/tsdd_master_model.sv
`timescale 1ns/1ps
module tsdd_master_model (
	input wire logic clk,
	output logic frame_n,
	output logic irdy_n,
	output logic [3:0] cbe_n,
	output logic [31:0] ad,
	output logic other_n,
	input wire logic devsel_n,
	input wire logic devsel_oe,
	input wire logic trdy_n,
	input wire logic trdy_oe,
	input wire logic stop_n,
	input wire logic stop_oe,
	input wire logic [31:0] ad_out,
	input wire logic ad_oe
);
	int claim_clk;
	int n_done;
	bit drove;
	bit order_bad;
	logic [31:0] rd_q[$];
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		other_n = 1'b1;
		cbe_n = 4'h0;
		ad = 32'h0000_0000;
	end
	// ==========================================
	// One transaction; wt delays the first ready, oth is another agent's claim clock
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
		input int n, input int wt, input int oth);
		int j;
		bit fin;
		bit stp;
		bit tr;
		bit st;
		j = 0;
		fin = 0;
		stp = 0;
		claim_clk = 0;
		n_done = 0;
		drove = 0;
		order_bad = 0;
		rd_q.delete();
		@(posedge clk);
		#1;
		frame_n = 1'b0;
		ad = addr;
		cbe_n = cmd;
		while (!fin && j < 80) begin
			@(posedge clk);
			tr = trdy_oe && !trdy_n;
			st = stop_oe && !stop_n;
			drove |= devsel_oe || trdy_oe || stop_oe || ad_oe;
			if (j > 0 && devsel_oe && !devsel_n && claim_clk == 0)
				claim_clk = j;
			if ((tr || st || ad_oe) && claim_clk == 0)
				order_bad = 1;
			if (claim_clk != 0 && !(devsel_oe && !devsel_n) && !st)
				order_bad = 1;
			if (!irdy_n && (tr || st)) begin
				if (tr && !cmd[0])
					rd_q.push_back(ad_out);
				if (tr)
					n_done++;
				fin = frame_n;
				stp = st;
			end
			if (claim_clk == 0 && j >= 5 && oth == 0)
				fin = 1;
			if (oth != 0 && j > oth)
				fin = 1;
			j++;
			#1;
			if (j == oth)
				other_n = 1'b0;
			if (!fin && j > wt) begin
				irdy_n = 1'b0;
				cbe_n = be;
				// Released lines toggle so a stale value never looks valid
				ad = cmd[0] ? 32'hD000_0000 + n_done : ~ad;
				frame_n = stp || (n - n_done <= 1);
			end
		end
		frame_n = 1'b1;
		irdy_n = 1'b1;
		other_n = 1'b1;
		ad = ~ad;
		cbe_n = ~cbe_n;
	endtask
endmodule
